// [inc/seq_step_consts.svh]
// constants for the sequencer step-action logic
`ifndef SEQ_STEP_CONSTS_SVH
`define SEQ_STEP_CONSTS_SVH
`define SSA_NUM_STEPS        16
`define SSA_STEP_W           4
`define SSA_NUM_REG          8
`define SSA_FIRST_LINREG     4
`define SSA_NUM_GPO          4
`define SSA_PD_GRP_W         8
`define SSA_WAIT_TIME_W      8
`define SSA_CLK_PERIOD_NS    40
`define SSA_MS_NS            1000000
`define SSA_MS_CYCLES        (`SSA_MS_NS / `SSA_CLK_PERIOD_NS)
`define SSA_WAIT_TIMEOUT_MS  500
`define SSA_MS_CNT_W         15
`define SSA_WAIT_CNT_W       9
`define SSA_POL_ACTIVE_HIGH  1'b1
`endif

// [inc/seq_step_pkg.sv]
// types shared by the sequencer step-action logic
`include "seq_step_consts.svh"
package seq_step_pkg;
   typedef struct packed {
      logic [`SSA_STEP_W-1:0] linreg_step_pointer;
      logic                   linreg_auto_ctrl;
      logic                   linreg_keep_on_cfg;
   } reg_cfg_t;

   typedef struct packed {
      logic [`SSA_STEP_W-1:0] output_rise_step;
      logic [`SSA_STEP_W-1:0] output_fall_step;
      logic                   polarity;
      logic                   seq_owned;
   } gpo_cfg_t;

   typedef struct packed {
      logic                        wait_en;
      logic [`SSA_STEP_W-1:0]      wait_step;
      logic                        wait_timeout_en;
      logic                        wait_delay_mode;
      logic [`SSA_WAIT_TIME_W-1:0] wait_time_ms;
   } wait_cfg_t;

   typedef enum logic [1:0] {
      W_IDLE  = 2'b00,
      W_EVENT = 2'b01,
      W_DELAY = 2'b11
   } wait_state_t;
endpackage : seq_step_pkg

// [src/seq_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module seq_pin_sync (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_pin,
   output logic      o_level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         level_r <= 1'b0;
      end
      else
      begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            level_r <= s3_r;
      end
   end

   assign o_level = level_r;
endmodule : seq_pin_sync

// [src/seq_reg_slot.sv]
// enable and A/B select for one regulator
`timescale 1ns/1ps
module seq_reg_slot (
   input  wire logic                     i_clk,
   input  wire logic                     i_sys_rst,
   input  wire seq_step_pkg::reg_cfg_t   i_cfg,
   input  wire logic                     i_hit,
   input  wire logic                     i_dir_up,
   input  wire logic                     i_boot_on,
   input  wire logic                     i_reset_mode,
   input  wire logic                     i_keep_in_reset,
   output logic                          o_en,
   output logic                          o_sel_b
);
   logic en_r;
   logic sel_b_r;
   logic up_on;
   logic dn_keep;

   assign up_on   = i_cfg.linreg_auto_ctrl | i_cfg.linreg_keep_on_cfg;
   assign dn_keep = i_cfg.linreg_keep_on_cfg;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         en_r    <= 1'b0;
         sel_b_r <= 1'b0;
      end
      else if (i_reset_mode)
      begin
         en_r    <= i_keep_in_reset;
         sel_b_r <= 1'b0;
      end
      else if (i_hit && i_dir_up)
      begin
         en_r    <= up_on;
         sel_b_r <= 1'b0;
      end
      else if (i_hit)
      begin
         en_r    <= dn_keep;
         sel_b_r <= dn_keep;
      end
      else if (i_boot_on)
      begin
         en_r    <= 1'b1;
         sel_b_r <= 1'b0;
      end
   end

   assign o_en    = en_r;
   assign o_sel_b = sel_b_r;
endmodule : seq_reg_slot

// [src/sequencer_step_actions.sv]
// step-action logic of the power sequencer: regulators, outputs, clock buffer, wait step
// Notes on behaviour
// - off config, or keep-on clear going down: disable at step, select A
// - going up, auto or keep-on set: enable at step with A
// - going down, keep-on set: stay enabled, switch to B setting
// - default supply set: step-0 regulators enabled on entering powered-down mode
// - otherwise step 0 behaves like any other step
// - default supply clear: step-0 assignments do nothing
// - first linreg stays on in reset mode when all three controls set
// - each sequencer-owned output toggles at its rise and fall steps
// - sequencer-owned outputs go inactive in reset mode
// - output pointers at step zero produce no transition
// - polarity sets idle level; direction decides which step asserts
// - a wait step above zero halts going up until third input event
// - wait timeout expiry skips later steps and requests shutdown
// - timeout shutdown sets a readable wait-shutdown flag
// - delay mode turns wait step into a programmable fixed delay
// - clock buffer on at its step going up, off going down
// - pd group on above its step going up, off below going down
// - sixteen steps, each pointer names one of them
// - pointers above maximum count are not sequencer controlled
// - power-down replays power-up assignments in reverse
`include "seq_step_consts.svh"
`timescale 1ns/1ps
module sequencer_step_actions #(
   parameter int unsigned P_MS_CYCLES = `SSA_MS_CYCLES
) (
   input  wire logic                                            i_clk,
   input  wire logic                                            i_sys_rst,
   input  wire logic [`SSA_STEP_W-1:0]                          i_step,
   input  wire logic                                            i_step_arrive,
   input  wire logic                                            i_dir_up,
   input  wire logic [`SSA_STEP_W-1:0]                          i_max_count,
   input  wire logic                                            i_enter_powerdown,
   input  wire logic                                            i_reset_mode,
   input  wire logic                                            i_default_supply_ctrl,
   input  wire logic                                            i_first_linreg_on,
   input  wire seq_step_pkg::reg_cfg_t [`SSA_NUM_REG-1:0]       i_reg_cfg,
   input  wire seq_step_pkg::gpo_cfg_t [`SSA_NUM_GPO-1:0]       i_gpo_cfg,
   input  wire logic [`SSA_STEP_W-1:0]                          i_slow_clock_buffer_step,
   input  wire logic [`SSA_STEP_W-1:0]                          i_pd_group_step,
   input  wire logic [`SSA_PD_GRP_W-1:0]                        i_pd_group_select,
   input  wire seq_step_pkg::wait_cfg_t                         i_wait_cfg,
   input  wire logic                                            i_third_general_input,
   input  wire logic                                            i_third_input_event_clr,
   input  wire logic                                            i_wait_shut_clr,
   output logic [`SSA_NUM_REG-1:0]                              o_reg_en,
   output logic [`SSA_NUM_REG-1:0]                              o_reg_sel_b,
   output logic [`SSA_NUM_GPO-1:0]                              o_gpo,
   output logic                                                 o_slow_clock_buffer_on,
   output logic [`SSA_PD_GRP_W-1:0]                             o_pd_group_on,
   output logic                                                 o_seq_hold,
   output logic                                                 o_wait_shutdown_req,
   output logic                                                 o_third_input_event,
   output logic                                                 o_wait_shut
);
   localparam int unsigned TIMEOUT_MS = `SSA_WAIT_TIMEOUT_MS;
   localparam logic [`SSA_MS_CNT_W-1:0] MS_LAST = `SSA_MS_CNT_W'(P_MS_CYCLES - 1);
   localparam logic [`SSA_WAIT_CNT_W-1:0] TIMEOUT_CNT = `SSA_WAIT_CNT_W'(TIMEOUT_MS);

   // step qualification of the regulator pointers
   logic [`SSA_NUM_REG-1:0] reg_hit;
   logic [`SSA_NUM_REG-1:0] reg_boot;
   logic [`SSA_NUM_REG-1:0] reg_keep;
   logic [`SSA_NUM_REG-1:0] reg_up_on;
   logic [`SSA_NUM_REG-1:0] reg_dn_b;

   genvar g;
   generate
      for (g = 0; g < `SSA_NUM_REG; g++)
      begin : g_reg
         logic ptr_live;
         // step 0 only counts as a default-supply step
         assign ptr_live = (i_reg_cfg[g].linreg_step_pointer <= i_max_count) &&
                           ((i_reg_cfg[g].linreg_step_pointer != 4'h0) ||
                            i_default_supply_ctrl);
         assign reg_hit[g] = i_step_arrive && ptr_live &&
                             (i_reg_cfg[g].linreg_step_pointer == i_step);
         assign reg_boot[g] = i_enter_powerdown && i_default_supply_ctrl &&
                              (i_reg_cfg[g].linreg_step_pointer == 4'h0);
         assign reg_keep[g] = (g == `SSA_FIRST_LINREG) && i_default_supply_ctrl &&
                              i_reg_cfg[g].linreg_keep_on_cfg && i_first_linreg_on;
         assign reg_up_on[g] = reg_hit[g] && i_dir_up &&
                               (i_reg_cfg[g].linreg_auto_ctrl | i_reg_cfg[g].linreg_keep_on_cfg);
         assign reg_dn_b[g] = reg_hit[g] && !i_dir_up && i_reg_cfg[g].linreg_keep_on_cfg;

         // same assignments serve both directions; down disables unless keep-on holds it enabled on B
         seq_reg_slot u_slot (
            .i_clk           (i_clk),
            .i_sys_rst       (i_sys_rst),
            .i_cfg           (i_reg_cfg[g]),
            .i_hit           (reg_hit[g]),
            .i_dir_up        (i_dir_up),
            .i_boot_on       (reg_boot[g]),
            .i_reset_mode    (i_reset_mode),
            .i_keep_in_reset (reg_keep[g]),
            .o_en            (o_reg_en[g]),
            .o_sel_b         (o_reg_sel_b[g])
         );
      end
   endgenerate

   // general-purpose outputs
   logic [`SSA_NUM_GPO-1:0] gpo_act_r;
   logic [`SSA_NUM_GPO-1:0] gpo_act_nxt;
   logic [`SSA_NUM_GPO-1:0] gpo_pin_r;
   logic [`SSA_NUM_GPO-1:0] gpo_pin_nxt;

   generate
      for (g = 0; g < `SSA_NUM_GPO; g++)
      begin : g_gpo
         logic rise_hit;
         logic fall_hit;
         logic owned;
         assign owned = i_gpo_cfg[g].seq_owned;
         assign rise_hit = i_step_arrive && owned &&
                           (i_gpo_cfg[g].output_rise_step != 4'h0) &&
                           (i_gpo_cfg[g].output_rise_step <= i_max_count) &&
                           (i_gpo_cfg[g].output_rise_step == i_step);
         assign fall_hit = i_step_arrive && owned &&
                           (i_gpo_cfg[g].output_fall_step != 4'h0) &&
                           (i_gpo_cfg[g].output_fall_step <= i_max_count) &&
                           (i_gpo_cfg[g].output_fall_step == i_step);
         assign gpo_act_nxt[g] = (i_reset_mode && owned) ? 1'b0 :
                                 (rise_hit ? i_dir_up :
                                 (fall_hit ? !i_dir_up : gpo_act_r[g]));
         // idle level follows polarity; the pin is registered from the state, so it lags it by a cycle
         assign gpo_pin_nxt[g] = (i_gpo_cfg[g].polarity == `SSA_POL_ACTIVE_HIGH) ?
                                 gpo_act_r[g] : !gpo_act_r[g];
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         gpo_act_r <= '0;
         gpo_pin_r <= '0;
      end
      else
      begin
         gpo_act_r <= gpo_act_nxt;
         gpo_pin_r <= gpo_pin_nxt;
      end
   end

   // slow clock buffer and power-down group
   logic clk_buf_hit;
   logic pd_live;
   logic pd_up_on;
   logic pd_dn_off;
   logic clk_buf_r;
   logic [`SSA_PD_GRP_W-1:0] pd_on_r;

   assign clk_buf_hit = i_step_arrive && (i_slow_clock_buffer_step != 4'h0) &&
                        (i_slow_clock_buffer_step <= i_max_count) &&
                        (i_slow_clock_buffer_step == i_step);
   assign pd_live   = (i_pd_group_step != 4'h0) && (i_pd_group_step <= i_max_count);
   assign pd_up_on  = i_step_arrive && pd_live && i_dir_up && (i_step > i_pd_group_step);
   assign pd_dn_off = i_step_arrive && pd_live && !i_dir_up && (i_step < i_pd_group_step);

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         clk_buf_r <= 1'b0;
         pd_on_r   <= '0;
      end
      else
      begin
         if (clk_buf_hit)
            clk_buf_r <= i_dir_up;
         if (pd_up_on)
            pd_on_r <= i_pd_group_select;
         else if (pd_dn_off)
            pd_on_r <= '0;
      end
   end

   // third input event capture; a set in the clear cycle wins
   logic gpi_level;
   logic gpi_prev_r;
   logic evt_r;
   logic evt_nxt;
   logic evt_set;

   seq_pin_sync u_gpi_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_third_general_input),
      .o_level   (gpi_level)
   );

   assign evt_set = gpi_level && !gpi_prev_r;
   assign evt_nxt = evt_set || (evt_r && !i_third_input_event_clr);

   // millisecond enable for the wait delay and timeout
   logic [`SSA_MS_CNT_W-1:0] ms_cnt_r;
   logic ms_tick;
   assign ms_tick = (ms_cnt_r == MS_LAST);

   // wait step state machine
   seq_step_pkg::wait_state_t wst_r;
   seq_step_pkg::wait_state_t wst_nxt;
   logic [`SSA_WAIT_CNT_W-1:0] wcnt_r;
   logic wait_hit;
   logic tmo_fire;
   logic delay_done;
   logic shut_r;
   logic shut_req_r;
   logic hold_r;

   assign wait_hit = i_step_arrive && i_dir_up && i_wait_cfg.wait_en &&
                     (i_wait_cfg.wait_step != 4'h0) && (i_wait_cfg.wait_step <= i_max_count) &&
                     (i_wait_cfg.wait_step == i_step);
   assign tmo_fire = (wst_r == seq_step_pkg::W_EVENT) && i_wait_cfg.wait_timeout_en &&
                     ms_tick && (wcnt_r >= TIMEOUT_CNT - 9'h001);
   assign delay_done = (wst_r == seq_step_pkg::W_DELAY) &&
                       (wcnt_r >= {1'b0, i_wait_cfg.wait_time_ms});

   always_comb
   begin
      wst_nxt = wst_r;
      case (wst_r)
         seq_step_pkg::W_IDLE:
            if (wait_hit && i_wait_cfg.wait_delay_mode)
               wst_nxt = seq_step_pkg::W_DELAY;
            else if (wait_hit && !evt_r)
               wst_nxt = seq_step_pkg::W_EVENT;
         seq_step_pkg::W_EVENT:
            if (evt_r || tmo_fire || i_reset_mode)
               wst_nxt = seq_step_pkg::W_IDLE;
         seq_step_pkg::W_DELAY:
            if (delay_done || i_reset_mode)
               wst_nxt = seq_step_pkg::W_IDLE;
         default:
            wst_nxt = seq_step_pkg::W_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         gpi_prev_r <= 1'b0;
         evt_r      <= 1'b0;
         ms_cnt_r   <= '0;
         wst_r      <= seq_step_pkg::W_IDLE;
         wcnt_r     <= '0;
         shut_r     <= 1'b0;
         shut_req_r <= 1'b0;
         hold_r     <= 1'b0;
      end
      else
      begin
         gpi_prev_r <= gpi_level;
         evt_r      <= evt_nxt;
         // divider restarts at each wait entry so delays are whole ms
         ms_cnt_r   <= (wst_r == seq_step_pkg::W_IDLE || ms_tick) ? '0 : ms_cnt_r + 1'b1;
         wst_r      <= wst_nxt;
         if (wst_r == seq_step_pkg::W_IDLE)
            wcnt_r <= '0;
         else if (ms_tick)
            wcnt_r <= wcnt_r + 1'b1;
         shut_req_r <= tmo_fire;
         shut_r     <= tmo_fire || (shut_r && !i_wait_shut_clr);
         hold_r     <= (wst_nxt != seq_step_pkg::W_IDLE);
      end
   end

   assign o_gpo                  = gpo_pin_r;
   assign o_slow_clock_buffer_on = clk_buf_r;
   assign o_pd_group_on          = pd_on_r;
   assign o_seq_hold             = hold_r;
   assign o_wait_shutdown_req    = shut_req_r;
   assign o_third_input_event    = evt_r;
   assign o_wait_shut            = shut_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   reg_reset_keep_a : assert property (i_reset_mode |=> o_reg_en == $past(reg_keep))
      else $error("regulator enable wrong in reset mode");
   reg_up_on_a : assert property (!i_reset_mode && |reg_up_on
      |=> (o_reg_en & $past(reg_up_on)) == $past(reg_up_on)
          && (o_reg_sel_b & $past(reg_up_on)) == '0)
      else $error("regulator not enabled on A going up");
   reg_dn_b_a : assert property (!i_reset_mode && |reg_dn_b
      |=> (o_reg_sel_b & $past(reg_dn_b)) == $past(reg_dn_b))
      else $error("regulator not switched to B going down");
   reg_off_a : assert property (!i_reset_mode && |(reg_hit & ~reg_up_on & ~reg_dn_b)
      |=> (o_reg_en & $past(reg_hit & ~reg_up_on & ~reg_dn_b)) == '0)
      else $error("regulator not disabled at its step");
   def_boot_a : assert property (!i_reset_mode && !i_step_arrive && |reg_boot
      |=> (o_reg_en & $past(reg_boot)) == $past(reg_boot))
      else $error("default supply not enabled");
   gpo_reset_a : assert property (i_reset_mode [*2] |=>
      ((o_gpo ^ ~{i_gpo_cfg[3].polarity, i_gpo_cfg[2].polarity,
                  i_gpo_cfg[1].polarity, i_gpo_cfg[0].polarity})
       & {i_gpo_cfg[3].seq_owned, i_gpo_cfg[2].seq_owned,
          i_gpo_cfg[1].seq_owned, i_gpo_cfg[0].seq_owned}) == '0 || $changed(i_gpo_cfg))
      else $error("owned output not idle in reset mode");
   clk_buf_a : assert property (clk_buf_hit
      |=> o_slow_clock_buffer_on == $past(i_dir_up))
      else $error("clock buffer did not follow its step");
   pd_group_a : assert property (pd_dn_off |=> o_pd_group_on == '0)
      else $error("pd group not disabled below its step");
   wait_hold_a : assert property (wst_r == seq_step_pkg::W_IDLE && wait_hit && !evt_r
      |=> o_seq_hold)
      else $error("wait step did not hold the sequence");
   wait_tmo_a : assert property (tmo_fire |=> o_wait_shutdown_req && o_wait_shut
      ##1 !o_wait_shutdown_req)
      else $error("timeout shutdown not signalled");
   evt_keep_a : assert property (evt_set |=> o_third_input_event)
      else $error("third input event lost");

   up_wait_c : cover property (wait_hit ##1 o_seq_hold ##[1:20] !o_seq_hold);
   tmo_c     : cover property (o_wait_shutdown_req);
   down_b_c  : cover property (|reg_dn_b);
   boot_c    : cover property (|reg_boot);
endmodule : sequencer_step_actions

// [verif/sequencer_step_actions_bench.sv]
// self-checking bench for the sequencer step-action logic
`include "seq_step_consts.svh"
`timescale 1ns/1ps
module sequencer_step_actions_bench;
   logic                                 clk, rst, arrive, dir_up, enter_pd, rst_mode;
   logic                                 def_sup, first_on, fire, host_clr, shut_clr, pin, ev_clr;
   logic [3:0]                           step, max_cnt, clk_step, pd_step, gpo;
   logic [7:0]                           pd_sel, reg_en, sel_b, pd_on;
   logic                                 clk_on, hold, shut_req, ev_flag, wshut;
   seq_step_pkg::reg_cfg_t [7:0]         reg_cfg;
   seq_step_pkg::gpo_cfg_t [3:0]         gpo_cfg;
   seq_step_pkg::wait_cfg_t              wait_cfg;
   int                                   err_count, check_count, n;
   // timeout span with the divider set to 4 cycles a ms below
   localparam int                        TMO_CYC = `SSA_WAIT_TIMEOUT_MS * 4;

   sequencer_step_actions #(.P_MS_CYCLES(4)) sequencer_step_actions_inst (
      .i_clk(clk), .i_sys_rst(rst), .i_step(step), .i_step_arrive(arrive), .i_dir_up(dir_up),
      .i_max_count(max_cnt), .i_enter_powerdown(enter_pd), .i_reset_mode(rst_mode),
      .i_default_supply_ctrl(def_sup), .i_first_linreg_on(first_on), .i_reg_cfg(reg_cfg),
      .i_gpo_cfg(gpo_cfg), .i_slow_clock_buffer_step(clk_step), .i_pd_group_step(pd_step),
      .i_pd_group_select(pd_sel), .i_wait_cfg(wait_cfg), .i_third_general_input(pin),
      .i_third_input_event_clr(ev_clr), .i_wait_shut_clr(shut_clr), .o_reg_en(reg_en),
      .o_reg_sel_b(sel_b), .o_gpo(gpo), .o_slow_clock_buffer_on(clk_on), .o_pd_group_on(pd_on),
      .o_seq_hold(hold), .o_wait_shutdown_req(shut_req), .o_third_input_event(ev_flag),
      .o_wait_shut(wshut));

   wake_source_model wake_source_model_inst (
      .i_clk(clk), .i_fire(fire), .i_host_clr(host_clr), .o_pin(pin), .o_event_clr(ev_clr));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // arrival pulse, then wait out the two-cycle output latency
   task automatic go(input logic [3:0] s, input logic up);
      step = s;
      dir_up = up;
      arrive = 1'b1;
      @(negedge clk) arrive = 1'b0;
      repeat (2) @(negedge clk);
   endtask : go

   task automatic pulse_pd;
      enter_pd = 1'b1;
      @(negedge clk) enter_pd = 1'b0;
      repeat (2) @(negedge clk);
   endtask : pulse_pd

   task automatic t_regs;
      reg_cfg[0] = '{4'h3, 1'b1, 1'b0};
      reg_cfg[1] = '{4'h3, 1'b0, 1'b1};
      reg_cfg[3] = '{4'h9, 1'b1, 1'b0};
      go(4'h3, 1'b1);
      check(reg_en, 8'h03);
      check(sel_b, 8'h00);
      go(4'h9, 1'b1);
      check(reg_en, 8'h03);
      go(4'h3, 1'b0);
      check(reg_en, 8'h02);
      check(sel_b, 8'h02);
   endtask : t_regs

   task automatic t_gpo;
      logic [3:0] st [5] = '{4'h2, 4'h5, 4'h5, 4'h2, 4'h0};
      logic       up [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      logic [1:0] ex [5] = '{2'b00, 2'b01, 2'b00, 2'b01, 2'b01};
      check(gpo[1:0], 2'b01);
      for (int i = 0; i < 5; i++)
      begin
         go(st[i], up[i]);
         check(gpo[1:0], ex[i]);
      end
   endtask : t_gpo

   task automatic t_clk_pd;
      go(4'h4, 1'b1);
      check(clk_on, 1'b1);
      check(pd_on, 8'h00);
      go(4'h5, 1'b1);
      check(pd_on, 8'hA5);
      go(4'h3, 1'b0);
      check(pd_on, 8'h00);
      go(4'h4, 1'b0);
      check(clk_on, 1'b0);
   endtask : t_clk_pd

   task automatic t_boot;
      reg_cfg[2] = '{4'h0, 1'b1, 1'b0};
      reg_cfg[4] = '{4'h0, 1'b0, 1'b1};
      go(4'h0, 1'b1);
      pulse_pd();
      check(reg_en, 8'h02);
      def_sup = 1'b1;
      pulse_pd();
      check(reg_en, 8'h16);
      go(4'h0, 1'b0);
      check(reg_en, 8'h12);
      go(4'h2, 1'b1);
      rst_mode = 1'b1;
      repeat (3) @(negedge clk);
      check(reg_en, 8'h10);
      check(gpo[1:0], 2'b01);
      first_on = 1'b0;
      repeat (2) @(negedge clk);
      check(reg_en, 8'h00);
      rst_mode = 1'b0;
      first_on = 1'b1;
   endtask : t_boot

   task automatic t_wait;
      wait_cfg = '{1'b1, 4'h6, 1'b0, 1'b0, 8'h00};
      go(4'h6, 1'b1);
      check(hold, 1'b1);
      fire = 1'b1;
      for (n = 0; n < 40 && hold !== 1'b0; n++) @(negedge clk);
      check(hold, 1'b0);
      check(ev_flag, 1'b1);
      fire = 1'b0;
      host_clr = 1'b1;
      @(negedge clk) host_clr = 1'b0;
      @(negedge clk);
      check(ev_flag, 1'b0);
      wait_cfg = '{1'b1, 4'h6, 1'b0, 1'b1, 8'h03};
      go(4'h6, 1'b1);
      repeat (5) @(negedge clk);
      check(hold, 1'b1);
      repeat (12) @(negedge clk);
      check(hold, 1'b0);
   endtask : t_wait

   task automatic t_timeout;
      wait_cfg = '{1'b1, 4'h6, 1'b1, 1'b0, 8'h00};
      go(4'h6, 1'b1);
      for (n = 0; n < 2200 && shut_req !== 1'b1; n++) @(negedge clk);
      check(shut_req, 1'b1);
      check(8'(n > TMO_CYC - 8 && n < TMO_CYC + 8), 8'h01);
      check(wshut, 1'b1);
      @(negedge clk) shut_clr = 1'b1;
      check(hold, 1'b0);
      @(negedge clk) shut_clr = 1'b0;
      @(negedge clk);
      check(wshut, 1'b0);
   endtask : t_timeout

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   initial
   begin
      {rst, arrive, dir_up, enter_pd, rst_mode, def_sup, fire, host_clr, shut_clr} = 9'h100;
      first_on = 1'b1;
      {step, max_cnt, clk_step, pd_step, pd_sel} = {4'h0, 4'h8, 4'h4, 4'h4, 8'hA5};
      for (int i = 0; i < 8; i++) reg_cfg[i] = '{4'hF, 1'b0, 1'b0};
      gpo_cfg = '0;
      gpo_cfg[0] = '{4'h2, 4'h5, 1'b0, 1'b1};
      gpo_cfg[1] = '{4'h0, 4'h0, 1'b1, 1'b1};
      wait_cfg = '{1'b0, 4'h6, 1'b0, 1'b0, 8'h00};
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (3) @(negedge clk);
      check(reg_en, 8'h00);
      t_regs();
      t_gpo();
      t_clk_pd();
      t_boot();
      t_wait();
      t_timeout();
      end_of_test();
   end

   // the whole run needs about 2100 cycles
   initial
   begin
      #(10000 * 40);
      err_count++;
      end_of_test();
   end
endmodule : sequencer_step_actions_bench

// [verif/wake_source_model.sv]
// far-side model: external wake source on the third input and host flag clear
`timescale 1ns/1ps
module wake_source_model (
   input  wire logic i_clk,
   input  wire logic i_fire,
   input  wire logic i_host_clr,
   output logic      o_pin,
   output logic      o_event_clr
);
   // one process owns the pin, so it has a single driver
   initial
   begin
      o_pin = 1'b0;
      forever
      begin
         @(posedge i_fire);
         // held high long enough to pass the pin filter
         repeat (2) @(negedge i_clk);
         o_pin = 1'b1;
         repeat (8) @(negedge i_clk);
         o_pin = 1'b0;
      end
   end
   assign o_event_clr = i_host_clr;
endmodule : wake_source_model
